// >>> bench/rbic_pin_source.sv
// board-side model of the reset, interrupt, fault and clock pin sources
`include "rbic_params.svh"
`timescale 1ns/10ps
module rbic_pin_source (
   // clock
   input  wire logic       mclk,
   // block's drive of the dual-purpose pins
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   // pins towards the block
   output logic            system_reset_n,
   output logic            power_on_reset_n,
   output logic            boot_memory_select,
   output logic            nmi_pin,
   output logic            drive_fault_irq_n,
   output logic            emulation_float_n,
   output logic            osc_bypass_n,
   output logic [1:0]      ext_irq_pin_in
);
   // interrupt pins idle low so a later rise is a real edge
   logic [6:0] pins = 7'h1C;

   assign boot_memory_select = pins[`RBIC_BIT_BOOT];
   assign nmi_pin            = pins[`RBIC_BIT_NMI];
   assign drive_fault_irq_n  = pins[`RBIC_BIT_FAULT];
   assign emulation_float_n  = pins[`RBIC_BIT_EMU];
   assign osc_bypass_n       = pins[`RBIC_BIT_BYP];
   // where the block drives a pin it wins; elsewhere the board source sets it
   assign ext_irq_pin_in = (pin_oe & pin_out) | (~pin_oe & pins[6:5]);

   initial begin
      system_reset_n = 1'b1;
      power_on_reset_n = 1'b1;
   end

   task set_pin(input int idx, input logic val);
      @(posedge mclk);
      #2;
      pins[idx] = val;
   endtask

   // pulled low between edges so the asynchronous path is exercised
   task assert_reset(input logic por);
      @(posedge mclk);
      #2;
      if (por) begin
         power_on_reset_n = 1'b0;
      end else begin
         system_reset_n = 1'b0;
      end
   endtask

   task release_reset;
      @(posedge mclk);
      #2;
      system_reset_n = 1'b1;
      power_on_reset_n = 1'b1;
   endtask
endmodule // rbic_pin_source

// >>> bench/tb_rbic_top.sv
// self-checking bench for the reset, boot and interrupt pin control block
`include "rbic_params.svh"
`timescale 1ns/10ps
module tb_rbic_top;
   import rbic_pkg::*;
   logic mclk, reset, sys_n, por_n, boot, nmi, fault_n, emu_n, byp_n;
   logic [1:0] pin_in, pin_out, pin_oe, pin_level, ext_ack, ext_req;
   logic [15:0] pc_next, pc;
   logic [7:0] ck_data, ckcr;
   logic mask, nmi_pol, nmi_ack, halt, ffetch, rclr, ckinit, boot_ext, nmi_req, irq;
   logic gpio_en, flt_en, hiz_clr, hiz, ck_en;
   rbic_gpio_cfg_t gpio_cfg;
   rbic_clk_status_t clk_st;
   int num_errors = 0;
   int n_compared = 0;
   logic [31:0] lfsr = 32'h2EF2;

   rbic_pin_source i_src (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .system_reset_n(sys_n), .power_on_reset_n(por_n), .boot_memory_select(boot),
      .nmi_pin(nmi), .drive_fault_irq_n(fault_n), .emulation_float_n(emu_n),
      .osc_bypass_n(byp_n), .ext_irq_pin_in(pin_in));

   rbic_top i_dut (.mclk(mclk), .reset(reset), .system_reset_n(sys_n),
      .power_on_reset_n(por_n), .boot_memory_select(boot), .nmi_pin(nmi),
      .drive_fault_irq_n(fault_n), .emulation_float_n(emu_n), .osc_bypass_n(byp_n),
      .ext_irq_pin_in(pin_in), .ext_irq_pin_out(pin_out), .ext_irq_pin_oe(pin_oe),
      .ext_pin_level(pin_level), .pc_next(pc_next), .global_irq_mask(mask),
      .nmi_polarity(nmi_pol), .nmi_ack(nmi_ack), .ext_irq_ack(ext_ack),
      .cpu_halt(halt), .first_fetch(ffetch), .program_counter(pc), .regs_clear(rclr),
      .clock_regs_init(ckinit), .boot_ext_mem(boot_ext), .nmi_req(nmi_req),
      .ext_irq_req(ext_req), .cpu_irq_req(irq), .gpio_wr_en(gpio_en),
      .gpio_wr_cfg(gpio_cfg), .drive_fault_enable(flt_en), .compare_hiz_clear(hiz_clr),
      .compare_hiz(hiz), .ckcr_wr_en(ck_en), .ckcr_wr_data(ck_data),
      .clock_ctrl_reg0(ckcr), .clk_status(clk_st));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task print_verdict;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   // bounded wait for the restart pulse at address zero, then the run state
   task wait_fetch;
      int k;
      for (k = 0; k < 20 && ffetch !== 1'b1; k++) tick(1);
      if (k == 20) begin
         num_errors++;
         disable scenario;
      end
      check(pc, 16'h0000);
      tick(1);
      check({ffetch, halt}, 2'h0);
   endtask

   task wr_ckcr(input logic [7:0] d);
      ck_data = d;
      ck_en = 1'b1;
      tick(1);
      ck_en = 1'b0;
      check(ckcr, d);
      tick(1);
      check(clk_st.use_pll, d[7] & byp_n);
   endtask

   initial begin
      {reset, mask, nmi_pol, nmi_ack, gpio_en, flt_en, hiz_clr, ck_en} = 8'hC0;
      {ext_ack, ck_data, pc_next, gpio_cfg} = '0;
      begin : scenario
         tick(3);
         check({halt, pc, pin_oe, ckcr, hiz}, {1'b1, 16'h0000, 2'h0, 8'h00, 1'b0});
         check(clk_st, 3'h1);
         reset = 1'b0;
         wait_fetch;
         lfsr = lfsr_next(lfsr);
         pc_next = lfsr[15:0];
         tick(3);
         check(pc, pc_next);
         for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr_ckcr({i[1:0], lfsr[5:0]});
         end
         i_src.set_pin(`RBIC_BIT_EMU, 1'b0);
         tick(4);
         check(clk_st.osc_out_oe, 1'b0);
         i_src.set_pin(`RBIC_BIT_EMU, 1'b1);
         i_src.set_pin(`RBIC_BIT_BYP, 1'b0);
         tick(4);
         check({clk_st.osc_bypass, clk_st.use_pll}, 2'h2);
         i_src.set_pin(`RBIC_BIT_BYP, 1'b1);
         for (int b = 1; b >= 0; b--) begin
            i_src.set_pin(`RBIC_BIT_BOOT, b[0]);
            tick(4);
            check(boot_ext, b[0]);
         end
         // mask held high: the nonmaskable request must still rise
         for (int p = 0; p < 2; p++) begin
            nmi_pol = p[0];
            i_src.set_pin(`RBIC_BIT_NMI, ~p[0]);
            tick(4);
            nmi_ack = 1'b1;
            tick(1);
            nmi_ack = 1'b0;
            tick(1);
            check(nmi_req, 1'b0);
            i_src.set_pin(`RBIC_BIT_NMI, p[0]);
            tick(4);
            check(nmi_req, 1'b1);
         end
         i_src.set_pin(`RBIC_BIT_FAULT, 1'b0);
         tick(4);
         check(hiz, 1'b0);
         i_src.set_pin(`RBIC_BIT_FAULT, 1'b1);
         tick(2);
         flt_en = 1'b1;
         i_src.set_pin(`RBIC_BIT_FAULT, 1'b0);
         tick(4);
         check(hiz, 1'b1);
         // the float outlasts the fault until software clears it
         i_src.set_pin(`RBIC_BIT_FAULT, 1'b1);
         tick(2);
         check(hiz, 1'b1);
         hiz_clr = 1'b1;
         tick(1);
         hiz_clr = 1'b0;
         check(hiz, 1'b0);
         // pin 0 becomes an output, pin 1 stays an interrupt input
         gpio_cfg.dir = 2'h1;
         gpio_cfg.out = 2'h1;
         gpio_en = 1'b1;
         tick(1);
         gpio_en = 1'b0;
         mask = 1'b0;
         tick(1);
         check({pin_oe, pin_out}, 4'h5);
         i_src.set_pin(`RBIC_BIT_XLO, 1'b1);
         i_src.set_pin(`RBIC_BIT_XHI, 1'b1);
         tick(3);
         // acknowledge in the cycle of the new edge: the edge must win
         ext_ack = 2'h2;
         tick(1);
         ext_ack = 2'h0;
         check({ext_req, irq, pin_level}, {2'h2, 1'b1, 2'h3});
         mask = 1'b1;
         tick(2);
         check(irq, 1'b0);
         ext_ack = 2'h3;
         tick(1);
         ext_ack = 2'h0;
         check(ext_req, 2'h0);
         i_src.assert_reset(1'b0);
         tick(3);
         check({halt, pc, rclr}, {1'b1, 16'h0000, 1'b1});
         check({pin_oe, ext_req}, 4'h0);
         check(ckcr[7:6], 2'h3);
         i_src.release_reset;
         wait_fetch;
         i_src.assert_reset(1'b1);
         tick(3);
         check({halt, pc, ckinit, ckcr}, {1'b1, 16'h0000, 1'b1, 8'h00});
         i_src.release_reset;
         wait_fetch;
      end
      print_verdict;
   end
endmodule // tb_rbic_top

// >>> design/rbic_pin_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module rbic_pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // pins and their synchronised levels
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         stage1 <= RESET_VAL;
         level  <= RESET_VAL;
      end else begin
         stage1 <= pin;
         level  <= stage1;
      end
   end

endmodule // rbic_pin_sync

// >>> design/rbic_reset_sync.sv
// reset synchroniser: asynchronous assertion, release on the clock
`timescale 1ns/10ps
module rbic_reset_sync (
   // clock and asynchronous reset request
   input  wire logic mclk,
   input  wire logic arst,
   // synchronised reset, active high
   output logic      rst_out
);

   logic stage1;

   always_ff @(posedge mclk or posedge arst) begin
      if (arst) begin
         stage1  <= 1'b1;
         rst_out <= 1'b1;
      end else begin
         stage1  <= 1'b0;
         rst_out <= stage1;
      end
   end

endmodule // rbic_reset_sync

// >>> design/rbic_top.sv
// reset, boot select, interrupt pin and clock pin control
`include "rbic_params.svh"
`timescale 1ns/10ps
module rbic_top #(
   parameter int PC_W = `RBIC_PC_W,
   parameter int CK_W = `RBIC_CLOCK_CTRL_REG0_W
) (
   // clock and global reset
   input  wire logic                      mclk,
   input  wire logic                      reset,
   // reset pins
   input  wire logic                      system_reset_n,
   input  wire logic                      power_on_reset_n,
   // boot and interrupt pins
   input  wire logic                      boot_memory_select,
   input  wire logic                      nmi_pin,
   input  wire logic                      drive_fault_irq_n,
   // clock pins
   input  wire logic                      emulation_float_n,
   input  wire logic                      osc_bypass_n,
   // dual-purpose interrupt pins
   input  wire logic [1:0]                ext_irq_pin_in,
   output logic      [1:0]                ext_irq_pin_out,
   output logic      [1:0]                ext_irq_pin_oe,
   output logic      [1:0]                ext_pin_level,
   // core side
   input  wire logic [PC_W-1:0]           pc_next,
   input  wire logic                      global_irq_mask,
   input  wire logic                      nmi_polarity,
   input  wire logic                      nmi_ack,
   input  wire logic [1:0]                ext_irq_ack,
   output logic                           cpu_halt,
   output logic                           first_fetch,
   output logic      [PC_W-1:0]           program_counter,
   output logic                           regs_clear,
   output logic                           clock_regs_init,
   output logic                           boot_ext_mem,
   output logic                           nmi_req,
   output logic      [1:0]                ext_irq_req,
   output logic                           cpu_irq_req,
   // pin direction and output value
   input  wire logic                      gpio_wr_en,
   input  wire rbic_pkg::rbic_gpio_cfg_t  gpio_wr_cfg,
   // drive-fault control
   input  wire logic                      drive_fault_enable,
   input  wire logic                      compare_hiz_clear,
   output logic                           compare_hiz,
   // clock control register
   input  wire logic                      ckcr_wr_en,
   input  wire logic [CK_W-1:0]           ckcr_wr_data,
   output logic      [CK_W-1:0]           clock_ctrl_reg0,
   output rbic_pkg::rbic_clk_status_t     clk_status
);
   import rbic_pkg::*;

   logic                    por_rst;
   logic                    sys_rst;
   logic [`RBIC_SYNC_W-1:0] pin_s;
   rbic_state_t             state;
   rbic_state_t             next_state;
   logic                    nmi_active;
   logic                    nmi_active_d;
   logic                    next_nmi_req;
   logic [1:0]              ext_prev;
   logic [1:0]              ext_rise;
   logic [1:0]              next_ext_req;
   rbic_gpio_cfg_t          gpio_cfg;

   // stage a pending flag: a new event beats a clear in the same cycle
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction

   // power-on reset also drives the system reset, so it resets all that system reset does plus the clock register
   rbic_reset_sync u_por_sync (
      .mclk    (mclk),
      .arst    (reset | ~power_on_reset_n),
      .rst_out (por_rst)
   );

   rbic_reset_sync u_sys_sync (
      .mclk    (mclk),
      .arst    (reset | ~power_on_reset_n | ~system_reset_n),
      .rst_out (sys_rst)
   );

   rbic_pin_sync #(
      .WIDTH     (`RBIC_SYNC_W),
      .RESET_VAL (`RBIC_SYNC_RESET)
   ) u_pin_sync (
      .mclk  (mclk),
      .reset (reset),
      .pin   ({ext_irq_pin_in, osc_bypass_n, emulation_float_n,
               drive_fault_irq_n, nmi_pin, boot_memory_select}),
      .level (pin_s)
   );

   assign regs_clear      = sys_rst;
   assign clock_regs_init = por_rst;

   // execution sequencing
   always_comb begin
      case (state)
         RBIC_HOLD:  next_state = RBIC_FIRST;
         RBIC_FIRST: next_state = RBIC_RUN;
         RBIC_RUN:   next_state = RBIC_RUN;
         default:    next_state = RBIC_HOLD;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state       <= RBIC_HOLD;
         cpu_halt    <= 1'b1;
         first_fetch <= 1'b0;
      end else begin
         state       <= next_state;
         cpu_halt    <= 1'b0;
         first_fetch <= (next_state == RBIC_FIRST);
      end
   end

   // the core's next address is ignored until the first fetch has gone out
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         program_counter <= `RBIC_PC_RESET;
      end else if (state == RBIC_RUN) begin
         program_counter <= pc_next;
      end else begin
         program_counter <= `RBIC_PC_RESET;
      end
   end

   // boot memory select follows the pin
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         boot_ext_mem <= 1'b0;
      end else begin
         boot_ext_mem <= pin_s[`RBIC_BIT_BOOT];
      end
   end

   // nonmaskable interrupt: polarity 1 means active high
   assign nmi_active   = pin_s[`RBIC_BIT_NMI] ~^ nmi_polarity;
   assign next_nmi_req = sticky(nmi_req, nmi_active & ~nmi_active_d, nmi_ack);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         nmi_active_d <= 1'b1;
         nmi_req      <= 1'b0;
      end else begin
         nmi_active_d <= nmi_active;
         nmi_req      <= next_nmi_req;
      end
   end

   // dual-purpose pins; a pin driven as output raises no interrupt
   assign ext_rise = ext_pin_level & ~ext_prev & ~gpio_cfg.dir;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         next_ext_req[i] = sticky(ext_irq_req[i], ext_rise[i], ext_irq_ack[i]);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gpio_cfg <= '0;
      end else if (gpio_wr_en) begin
         gpio_cfg <= gpio_wr_cfg;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_irq_pin_oe  <= 2'h0;
         ext_irq_pin_out <= 2'h0;
      end else begin
         ext_irq_pin_oe  <= gpio_cfg.dir;
         ext_irq_pin_out <= gpio_cfg.out;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_pin_level <= 2'h3;
         ext_prev      <= 2'h3;
         ext_irq_req   <= 2'h0;
         cpu_irq_req   <= 1'b0;
      end else begin
         ext_pin_level <= pin_s[`RBIC_BIT_XHI:`RBIC_BIT_XLO];
         ext_prev      <= ext_pin_level;
         ext_irq_req   <= next_ext_req;
         cpu_irq_req   <= (|next_ext_req) & ~global_irq_mask;
      end
   end

   // drive fault latches the float so a glitch-free restart needs software
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         compare_hiz <= 1'b0;
      end else begin
         compare_hiz <= sticky(compare_hiz,
                               drive_fault_enable & ~pin_s[`RBIC_BIT_FAULT],
                               compare_hiz_clear);
      end
   end

   // clock control survives system reset; only power-on reset or the global reset restores it
   always_ff @(posedge mclk or posedge por_rst) begin
      if (por_rst) begin
         clock_ctrl_reg0 <= `RBIC_CLOCK_CTRL_REG0_RESET;
      end else if (ckcr_wr_en) begin
         clock_ctrl_reg0 <= ckcr_wr_data;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clk_status <= '{use_pll: 1'b0, osc_bypass: 1'b0, osc_out_oe: 1'b1};
      end else begin
         clk_status.use_pll    <= clock_ctrl_reg0[`RBIC_CLOCK_SOURCE_MODE_MSB]
                                  & pin_s[`RBIC_BIT_BYP];
         clk_status.osc_bypass <= ~pin_s[`RBIC_BIT_BYP];
         clk_status.osc_out_oe <= pin_s[`RBIC_BIT_EMU];
      end
   end

   // checks
   halt_in_reset_a: assert property (
      @(posedge mclk) disable iff (reset)
      sys_rst |-> cpu_halt && program_counter == `RBIC_PC_RESET && !first_fetch
   ) else $error("core not halted at zero during reset");

   fetch_from_zero_a: assert property (
      @(posedge mclk) disable iff (reset)
      $fell(sys_rst) |=> first_fetch && !cpu_halt && program_counter == `RBIC_PC_RESET
   ) else $error("first fetch after reset not at zero");

   por_resets_all_a: assert property (
      @(posedge mclk) disable iff (reset)
      por_rst |-> sys_rst && cpu_halt
   ) else $error("power-on reset did not hold system reset");

   boot_select_a: assert property (
      @(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) && !$past(reset, 3)
      |-> boot_ext_mem == $past(boot_memory_select, 3)
   ) else $error("boot memory select does not follow the pin");

   nmi_unmasked_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      nmi_active && !nmi_active_d && global_irq_mask |=> nmi_req
   ) else $error("nmi blocked by the global mask");

   nmi_low_level_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !$past(sys_rst) && !nmi_polarity && $stable(nmi_polarity)
      && $fell(pin_s[`RBIC_BIT_NMI]) |=> nmi_req
   ) else $error("active low nmi not detected");

   ext_irq_set_wins_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (ext_rise & ext_irq_ack) != 2'h0
      |=> (ext_irq_req & $past(ext_rise & ext_irq_ack)) == $past(ext_rise & ext_irq_ack)
   ) else $error("interrupt lost under a clear");

   gpio_input_reset_a: assert property (
      @(posedge mclk) disable iff (reset)
      sys_rst |-> ext_irq_pin_oe == 2'h0 && gpio_cfg.dir == 2'h0
   ) else $error("interrupt pin driven during reset");

   fault_float_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      drive_fault_enable && !pin_s[`RBIC_BIT_FAULT] |=> compare_hiz
   ) else $error("compare outputs not floated on fault");

   fault_hold_a: assert property (
      @(posedge mclk) disable iff (sys_rst)
      compare_hiz && !compare_hiz_clear |=> compare_hiz
   ) else $error("compare float released without a clear");

   clk_reg_por_a: assert property (
      @(posedge mclk) disable iff (reset)
      por_rst |-> clock_ctrl_reg0 == `RBIC_CLOCK_CTRL_REG0_RESET
   ) else $error("clock register not initialised by power-on reset");

   clk_reg_keep_a: assert property (
      @(posedge mclk) disable iff (por_rst)
      sys_rst && !ckcr_wr_en |=> $stable(clock_ctrl_reg0)
   ) else $error("system reset altered the clock register");

   pll_mode_a: assert property (
      @(posedge mclk) disable iff (reset)
      clock_ctrl_reg0[`RBIC_CLOCK_SOURCE_MODE_MSB] && pin_s[`RBIC_BIT_BYP] |=> clk_status.use_pll
   ) else $error("pll source not selected");

   osc_float_a: assert property (
      @(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) && !$past(reset, 3)
      && !$past(emulation_float_n, 3) |-> !clk_status.osc_out_oe
   ) else $error("oscillator output not floated");

   osc_bypass_a: assert property (
      @(posedge mclk) disable iff (reset)
      !$past(reset) && !$past(reset, 2) && !$past(reset, 3)
      && !$past(osc_bypass_n, 3) |-> clk_status.osc_bypass && !clk_status.use_pll
   ) else $error("oscillator not bypassed");

endmodule // rbic_top

// >>> include/rbic_params.svh
// constants for the reset, boot and interrupt pin control block
`ifndef RBIC_PARAMS_SVH
`define RBIC_PARAMS_SVH

`define RBIC_PC_W          16
`define RBIC_PC_RESET      16'h0000
`define RBIC_CLOCK_CTRL_REG0_W       8
`define RBIC_CLOCK_CTRL_REG0_RESET   8'h00
`define RBIC_CLOCK_SOURCE_MODE_MSB     7
`define RBIC_CLOCK_SOURCE_MODE_LSB     6
`define RBIC_SYNC_W        7
`define RBIC_SYNC_RESET    7'h7E
`define RBIC_BIT_BOOT      0
`define RBIC_BIT_NMI       1
`define RBIC_BIT_FAULT     2
`define RBIC_BIT_EMU       3
`define RBIC_BIT_BYP       4
`define RBIC_BIT_XLO       5
`define RBIC_BIT_XHI       6

`endif

// >>> include/rbic_pkg.sv
// types for the reset, boot and interrupt pin control block
package rbic_pkg;

   typedef enum logic [1:0] {
      RBIC_HOLD,
      RBIC_FIRST,
      RBIC_RUN
   } rbic_state_t;

   typedef struct packed {
      logic [1:0] dir;
      logic [1:0] out;
   } rbic_gpio_cfg_t;

   typedef struct packed {
      logic use_pll;
      logic osc_bypass;
      logic osc_out_oe;
   } rbic_clk_status_t;

endpackage
